/* File: rtl/dmr_mode_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - register zero bit three picks sequential or interleaved read beat order
// - length field picks fixed chop, fixed eight, or per-command choice by A12
// - sequential eight reads wrap low two bits in the start half, then other half
// - interleaved eight reads give start column xor beat index
// - chop reads drive four beats then float data and strobes
// - chop writes use only A2 for the half, ascending, last four ignored
// - eight-beat writes fill columns zero to seven ascending
// - fixed chop pulls write reference two clocks earlier; on-the-fly chop does not
// - dll reset bit clears itself once the reset has been carried out
// - A9 to A11 hold write recovery, combined with precharge time
// - A12 selects frozen dll slow exit or running dll fast exit
// - set command with bank zero high only writes register one
// - set command with all banks low writes register zero
// - enabled dll turns off in self refresh and back on at exit
// - register one A1 and A5 select driver impedance
// - reads and writes wait additive latency; latencies add to cas values
// - register one bit twelve disconnects all data and strobe drivers
// - write termination applies in writes even with nominal termination off
module dmr_mode_ctrl
   import dmr_pkg::*;
#(
   parameter int DLLK_CYCLES = DMR_DLLK_CYC
) (
   // core clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // link clock and command pins
   input wire logic link_clk_i,
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [12:0] addr_i,
   input wire logic odt_i,
   // settings held in the other mode registers
   input wire logic [4:0] cwl_i,
   input wire logic [1:0] rtt_wr_i,
   input wire logic [4:0] trp_cycles_i,
   // link-side data path control
   output logic [2:0] rd_col_o,
   output logic rd_beat_o,
   output logic dq_oe_n_o,
   output logic dqs_oe_n_o,
   output logic [2:0] wr_col_o,
   output logic wr_beat_o,
   output logic wr_ref_o,
   output logic cmd_ready_o,
   output logic term_wr_o,
   output logic [2:0] term_code_o,
   // core-side decoded settings
   output logic [1:0] bl_mode_o,
   output logic burst_ileave_o,
   output logic [4:0] cas_lat_o,
   output logic [4:0] add_lat_o,
   output logic [4:0] wr_rec_o,
   output logic [5:0] dal_o,
   output logic ppd_fast_o,
   output logic [1:0] drv_imp_o,
   output logic [2:0] rtt_nom_o,
   output logic out_off_o,
   output logic wlvl_o,
   output logic dll_locked_o,
   output logic dll_running_o
);
   // link domain state
   logic lrst_meta_reg, lrst_reg;
   logic ack_meta_reg, ack_sync_reg, ack_seen_reg;
   logic [12:0] mr0_reg, mr1_reg;
   logic mr_tgl_reg, dll_req_tgl_reg, dll_on_reg;
   logic cke_q_reg, sr_reg, pd_reg;
   logic [3:0] exit_cnt_reg;
   dmr_burst_t bstate_reg;
   logic [5:0] lat_cnt_reg;
   logic [2:0] beat_reg, start_col_reg;
   logic bwr_reg, chop_reg, fixchop_reg;
   // core domain state
   logic mrt_meta_reg, mrt_sync_reg, mrt_seen_reg;
   logic [12:0] cmr0_reg, cmr1_reg;
   // combinational helpers
   logic cmd_ok, is_mrs, is_rd, is_wr, is_ref_raw, ack_evt;
   logic [4:0] cl_lnk, al_lnk, cl_core, al_core;
   logic [5:0] lat_next;
   logic dll_ack_tgl;

   dmr_ord_if u_ord_if ();

   // link reset follows the core reset through two flops
   always_ff @(posedge link_clk_i) begin
      lrst_meta_reg <= rst_i;
      lrst_reg <= lrst_meta_reg;
   end

   // dll acknowledge crossing back onto the link clock
   always_ff @(posedge link_clk_i) begin
      ack_meta_reg <= dll_ack_tgl;
      ack_sync_reg <= ack_meta_reg;
   end

   assign ack_evt = ack_sync_reg ^ ack_seen_reg;

   // command decode; clock enable must be high on this and the previous edge
   assign cmd_ok = cke_q_reg & cke_i & ~cs_n_i;
   assign is_mrs = cmd_ok & ~ras_n_i & ~cas_n_i & ~we_n_i;
   assign is_rd = cmd_ok & ras_n_i & ~cas_n_i & we_n_i;
   assign is_wr = cmd_ok & ras_n_i & ~cas_n_i & ~we_n_i;
   assign is_ref_raw = ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i;

   // latency figures from the link copies of the registers
   assign cl_lnk = {mr0_reg[DMR_MR0_CL_EXT], mr0_reg[DMR_MR0_CL_LO +: 3]} + DMR_CL_BASE;
   always_comb begin
      case (mr1_reg[DMR_MR1_AL_LO +: 2])
         DMR_AL_CL1: al_lnk = cl_lnk - 5'h01;
         DMR_AL_CL2: al_lnk = cl_lnk - 5'h02;
         default: al_lnk = 5'h00; // reserved code treated as zero
      endcase
   end
   // read waits al+cl, write waits al+cwl
   assign lat_next = is_wr ? ({1'b0, al_lnk} + {1'b0, cwl_i}) : ({1'b0, al_lnk} + {1'b0, cl_lnk});

   // mode register zero; a new write beats the self-clear in the same cycle
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         mr0_reg <= DMR_MR0_RST;
      end else if (is_mrs && ba_i == DMR_BA_MR0) begin
         mr0_reg <= addr_i;
      end else if (ack_evt) begin
         mr0_reg[DMR_MR0_DLLRST] <= 1'b0;
      end
   end

   // mode register one
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         mr1_reg <= DMR_MR1_RST;
      end else if (is_mrs && ba_i == DMR_BA_MR1) begin
         mr1_reg <= addr_i;
      end
   end

   // handshake toggles toward the core domain
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         mr_tgl_reg <= 1'b0;
         dll_req_tgl_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else begin
         ack_seen_reg <= ack_sync_reg;
         if ((is_mrs && (ba_i == DMR_BA_MR0 || ba_i == DMR_BA_MR1)) || ack_evt) begin
            mr_tgl_reg <= ~mr_tgl_reg;
         end
         if (is_mrs && ba_i == DMR_BA_MR0 && addr_i[DMR_MR0_DLLRST]) begin
            dll_req_tgl_reg <= ~dll_req_tgl_reg;
         end
      end
   end

   // power states from clock enable edges
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         cke_q_reg <= 1'b0;
         sr_reg <= 1'b0;
         pd_reg <= 1'b0;
      end else begin
         cke_q_reg <= cke_i;
         if (cke_i) begin
            sr_reg <= 1'b0;
            pd_reg <= 1'b0;
         end else if (cke_q_reg) begin
            sr_reg <= is_ref_raw;
            pd_reg <= ~is_ref_raw;
         end
      end
   end

   // dll runs unless disabled, in self refresh, or frozen in slow-exit power-down
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         dll_on_reg <= 1'b0;
      end else begin
         dll_on_reg <= ~mr1_reg[DMR_MR1_DLL_DIS] & ~sr_reg & ~(pd_reg & ~mr0_reg[DMR_MR0_PPD]);
      end
   end

   // exit wait before commands are accepted again
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         exit_cnt_reg <= 4'h0;
         cmd_ready_o <= 1'b0;
      end else begin
         if (cke_i && (sr_reg || (pd_reg && !mr0_reg[DMR_MR0_PPD]))) begin
            exit_cnt_reg <= DMR_XPDLL_NCK;
         end else if (cke_i && pd_reg) begin
            exit_cnt_reg <= DMR_XP_NCK;
         end else if (exit_cnt_reg != 4'h0) begin
            exit_cnt_reg <= exit_cnt_reg - 4'h1;
         end
         cmd_ready_o <= cke_i & ~sr_reg & ~pd_reg & (exit_cnt_reg <= 4'h1);
      end
   end

   // burst sequencer; one outstanding access, commands while busy are dropped
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         bstate_reg <= BS_IDLE;
         lat_cnt_reg <= 6'h00;
         beat_reg <= 3'h0;
         start_col_reg <= 3'h0;
         bwr_reg <= 1'b0;
         chop_reg <= 1'b0;
         fixchop_reg <= 1'b0;
      end else begin
         case (bstate_reg)
            BS_IDLE: begin
               if ((is_rd || is_wr) && cmd_ready_o) begin
                  bstate_reg <= BS_WAIT;
                  lat_cnt_reg <= (lat_next > 6'h03) ? lat_next - 6'h03 : 6'h00;
                  start_col_reg <= addr_i[2:0];
                  bwr_reg <= is_wr;
                  fixchop_reg <= mr0_reg[DMR_MR0_BL_LO +: 2] == DMR_BL_FIX4;
                  chop_reg <= (mr0_reg[DMR_MR0_BL_LO +: 2] == DMR_BL_FIX4) ||
                     ((mr0_reg[DMR_MR0_BL_LO +: 2] == DMR_BL_OTF) && !addr_i[12]);
               end
            end
            BS_WAIT: begin
               if (lat_cnt_reg == 6'h00) begin
                  bstate_reg <= BS_BURST;
                  beat_reg <= 3'h0;
               end else begin
                  lat_cnt_reg <= lat_cnt_reg - 6'h01;
               end
            end
            BS_BURST: begin
               beat_reg <= beat_reg + 3'h1;
               if (beat_reg == 3'h7) begin
                  bstate_reg <= BS_IDLE; // chop keeps all eight slots
               end
            end
            default: bstate_reg <= BS_IDLE;
         endcase
      end
   end

   // ordering request to the beat calculator
   assign u_ord_if.start_col = start_col_reg;
   assign u_ord_if.beat = beat_reg;
   assign u_ord_if.interleave = mr0_reg[DMR_MR0_BT];
   assign u_ord_if.is_wr = bwr_reg;
   assign u_ord_if.chop = chop_reg;

   dmr_beat_order u_order (
      .ord (u_ord_if)
   );

   // registered data path strobes; output-off floats drivers but keeps order
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         rd_col_o <= 3'h0;
         rd_beat_o <= 1'b0;
         dq_oe_n_o <= 1'b1;
         dqs_oe_n_o <= 1'b1;
         wr_col_o <= 3'h0;
         wr_beat_o <= 1'b0;
      end else begin
         rd_col_o <= u_ord_if.col;
         rd_beat_o <= (bstate_reg == BS_BURST) & ~bwr_reg & u_ord_if.drive;
         dq_oe_n_o <= ~((bstate_reg == BS_BURST) & ~bwr_reg & u_ord_if.drive &
            ~mr1_reg[DMR_MR1_QOFF]);
         dqs_oe_n_o <= ~((bstate_reg == BS_BURST) & ~bwr_reg & u_ord_if.drive &
            ~mr1_reg[DMR_MR1_QOFF]);
         wr_col_o <= u_ord_if.col;
         wr_beat_o <= (bstate_reg == BS_BURST) & bwr_reg & u_ord_if.drive;
      end
   end

   // write timing reference; only a fixed chop is pulled in
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         wr_ref_o <= 1'b0;
      end else begin
         wr_ref_o <= (bstate_reg == BS_BURST) & bwr_reg &
            (beat_reg == (fixchop_reg ? DMR_WREF_BC4 : DMR_WREF_BL8));
      end
   end

   // termination select; write value wins inside a write burst
   always_ff @(posedge link_clk_i) begin
      if (lrst_reg) begin
         term_wr_o <= 1'b0;
         term_code_o <= 3'h0;
      end else if (!odt_i) begin
         term_wr_o <= 1'b0;
         term_code_o <= 3'h0;
      end else if ((bstate_reg == BS_BURST) && bwr_reg && (rtt_wr_i != 2'h0)) begin
         term_wr_o <= 1'b1;
         term_code_o <= {1'b0, rtt_wr_i};
      end else begin
         term_wr_o <= 1'b0;
         term_code_o <= {mr1_reg[DMR_MR1_RTT_HI], mr1_reg[DMR_MR1_RTT_MID],
            mr1_reg[DMR_MR1_RTT_LO]};
      end
   end

   // register word crossing; the word is held for the set-command spacing
   always_ff @(posedge clk_i) begin
      mrt_meta_reg <= mr_tgl_reg;
      mrt_sync_reg <= mrt_meta_reg;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mrt_seen_reg <= 1'b0;
         cmr0_reg <= DMR_MR0_RST;
         cmr1_reg <= DMR_MR1_RST;
      end else begin
         mrt_seen_reg <= mrt_sync_reg;
         if (mrt_sync_reg ^ mrt_seen_reg) begin
            cmr0_reg <= mr0_reg;
            cmr1_reg <= mr1_reg;
         end
      end
   end

   // core copies of the latency decode
   assign cl_core = {cmr0_reg[DMR_MR0_CL_EXT], cmr0_reg[DMR_MR0_CL_LO +: 3]} + DMR_CL_BASE;
   always_comb begin
      case (cmr1_reg[DMR_MR1_AL_LO +: 2])
         DMR_AL_CL1: al_core = cl_core - 5'h01;
         DMR_AL_CL2: al_core = cl_core - 5'h02;
         default: al_core = 5'h00;
      endcase
   end

   // decoded settings, registered for clean outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bl_mode_o <= DMR_BL_FIX8;
         burst_ileave_o <= 1'b0;
         cas_lat_o <= 5'h00;
         add_lat_o <= 5'h00;
         ppd_fast_o <= 1'b0;
         drv_imp_o <= 2'h0;
         rtt_nom_o <= 3'h0;
         out_off_o <= 1'b0;
         wlvl_o <= 1'b0;
      end else begin
         bl_mode_o <= cmr0_reg[DMR_MR0_BL_LO +: 2];
         burst_ileave_o <= cmr0_reg[DMR_MR0_BT];
         cas_lat_o <= cl_core;
         add_lat_o <= al_core;
         ppd_fast_o <= cmr0_reg[DMR_MR0_PPD];
         drv_imp_o <= {cmr1_reg[DMR_MR1_DIC_HI], cmr1_reg[DMR_MR1_DIC_LO]};
         rtt_nom_o <= {cmr1_reg[DMR_MR1_RTT_HI], cmr1_reg[DMR_MR1_RTT_MID],
            cmr1_reg[DMR_MR1_RTT_LO]};
         out_off_o <= cmr1_reg[DMR_MR1_QOFF];
         wlvl_o <= cmr1_reg[DMR_MR1_WLVL];
      end
   end

   // write recovery and auto-precharge delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_rec_o <= 5'h00;
         dal_o <= 6'h00;
      end else begin
         case (cmr0_reg[DMR_MR0_WR_LO +: 3])
            3'h0: wr_rec_o <= 5'h10;
            3'h5: wr_rec_o <= 5'h0a;
            3'h6: wr_rec_o <= 5'h0c;
            3'h7: wr_rec_o <= 5'h0e;
            default: wr_rec_o <= {2'h0, cmr0_reg[DMR_MR0_WR_LO +: 3]} + 5'h04;
         endcase
         dal_o <= {1'b0, wr_rec_o} + {1'b0, trp_cycles_i};
      end
   end

   // dll lock sequencing on the core clock
   dmr_dll_core #(
      .LOCK_CYCLES (DLLK_CYCLES)
   ) u_dll (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .req_tgl_i (dll_req_tgl_reg),
      .dll_on_i (dll_on_reg),
      .ack_tgl_o (dll_ack_tgl),
      .locked_o (dll_locked_o),
      .running_o (dll_running_o)
   );
endmodule : dmr_mode_ctrl
`default_nettype wire

/* File: rtl/dmr_pkg.sv */
package dmr_pkg;
   // pin widths
   localparam int DMR_ADDR_W = 13;
   localparam logic [2:0] DMR_BA_MR0 = 3'h0;
   localparam logic [2:0] DMR_BA_MR1 = 3'h1;
   // register zero field positions
   localparam int DMR_MR0_BL_LO = 0;
   localparam int DMR_MR0_CL_EXT = 2;
   localparam int DMR_MR0_BT = 3;
   localparam int DMR_MR0_CL_LO = 4;
   localparam int DMR_MR0_DLLRST = 8;
   localparam int DMR_MR0_WR_LO = 9;
   localparam int DMR_MR0_PPD = 12;
   // register one field positions
   localparam int DMR_MR1_DLL_DIS = 0;
   localparam int DMR_MR1_DIC_LO = 1;
   localparam int DMR_MR1_RTT_LO = 2;
   localparam int DMR_MR1_AL_LO = 3;
   localparam int DMR_MR1_DIC_HI = 5;
   localparam int DMR_MR1_RTT_MID = 6;
   localparam int DMR_MR1_WLVL = 7;
   localparam int DMR_MR1_RTT_HI = 9;
   localparam int DMR_MR1_QOFF = 12;
   // reset values
   localparam logic [12:0] DMR_MR0_RST = 13'h0000;
   localparam logic [12:0] DMR_MR1_RST = 13'h0000;
   // burst length field codes
   localparam logic [1:0] DMR_BL_FIX8 = 2'h0;
   localparam logic [1:0] DMR_BL_OTF = 2'h1;
   localparam logic [1:0] DMR_BL_FIX4 = 2'h2;
   // additive latency codes
   localparam logic [1:0] DMR_AL_CL1 = 2'h1;
   localparam logic [1:0] DMR_AL_CL2 = 2'h2;
   localparam logic [4:0] DMR_CL_BASE = 5'h04;
   // beat at which the internal write reference fires
   localparam logic [2:0] DMR_WREF_BL8 = 3'h7;
   localparam logic [2:0] DMR_WREF_BC4 = 3'h5;
   // power-down exit waits in link clocks
   localparam logic [3:0] DMR_XP_NCK = 4'h3;
   localparam logic [3:0] DMR_XPDLL_NCK = 4'ha;
   // dll lock time on the core clock
   localparam int DMR_CLK_NS = 50;
   localparam int DMR_DLLK_NS = 25600;
   localparam int DMR_DLLK_CYC = (DMR_DLLK_NS + DMR_CLK_NS - 1) / DMR_CLK_NS;
   // state types
   typedef enum logic [1:0] {BS_IDLE, BS_WAIT, BS_BURST} dmr_burst_t;
   typedef enum logic [1:0] {DS_OFF, DS_LOCK, DS_RUN} dmr_dll_t;
endpackage : dmr_pkg

/* File: rtl/dmr_ord_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dmr_ord_if;
   logic [2:0] start_col;
   logic [2:0] beat;
   logic interleave;
   logic is_wr;
   logic chop;
   logic [2:0] col;
   logic drive;
   modport req (output start_col, beat, interleave, is_wr, chop, input col, drive);
   modport calc (input start_col, beat, interleave, is_wr, chop, output col, drive);
endinterface : dmr_ord_if
`default_nettype wire

/* File: rtl/dmr_beat_order.sv */
`timescale 1ns/100ps
`default_nettype none
module dmr_beat_order (
   // burst ordering request and answer
   dmr_ord_if.calc ord
);
   // column for one beat; pure logic so the caller registers it
   always_comb begin
      ord.drive = ~(ord.chop & ord.beat[2]);
      if (ord.is_wr) begin
         if (ord.chop) begin
            ord.col = {ord.start_col[2], ord.beat[1:0]};
         end else begin
            ord.col = ord.beat;
         end
      end else if (ord.interleave) begin
         ord.col = ord.start_col ^ ord.beat;
      end else begin
         // low pair wraps inside its half, top bit flips the half
         ord.col = {ord.start_col[2] ^ ord.beat[2], ord.start_col[1:0] + ord.beat[1:0]};
      end
   end
endmodule : dmr_beat_order
`default_nettype wire

/* File: rtl/dmr_dll_core.sv */
`timescale 1ns/100ps
`default_nettype none
module dmr_dll_core
   import dmr_pkg::*;
#(
   parameter int LOCK_CYCLES = DMR_DLLK_CYC
) (
   // core clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // requests from the link domain
   input wire logic req_tgl_i,
   input wire logic dll_on_i,
   // answers
   output logic ack_tgl_o,
   output logic locked_o,
   output logic running_o
);
   logic req_meta_reg, req_sync_reg, req_seen_reg;
   logic on_meta_reg, on_sync_reg;
   logic [12:0] cnt_reg;
   dmr_dll_t state_reg;
   logic req_evt;

   // two-flop crossings; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      req_meta_reg <= req_tgl_i;
      req_sync_reg <= req_meta_reg;
      on_meta_reg <= dll_on_i;
      on_sync_reg <= on_meta_reg;
   end

   assign req_evt = req_sync_reg ^ req_seen_reg;

   // lock sequencing; every reset or re-enable restarts the wait
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= DS_OFF;
         cnt_reg <= 13'h0000;
         req_seen_reg <= 1'b0;
         ack_tgl_o <= 1'b0;
      end else begin
         req_seen_reg <= req_sync_reg;
         if (req_evt) begin
            ack_tgl_o <= ~ack_tgl_o;
         end
         case (state_reg)
            DS_OFF: begin
               if (on_sync_reg) begin
                  state_reg <= DS_LOCK;
                  cnt_reg <= 13'h0000;
               end
            end
            DS_LOCK, DS_RUN: begin
               if (!on_sync_reg) begin
                  state_reg <= DS_OFF;
               end else if (req_evt) begin
                  state_reg <= DS_LOCK;
                  cnt_reg <= 13'h0000;
               end else if (state_reg == DS_LOCK) begin
                  if (cnt_reg == 13'(LOCK_CYCLES - 1)) begin
                     state_reg <= DS_RUN;
                  end else begin
                     cnt_reg <= cnt_reg + 13'h0001;
                  end
               end
            end
            default: state_reg <= DS_OFF;
         endcase
      end
   end

   // registered status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         locked_o <= 1'b0;
         running_o <= 1'b0;
      end else begin
         locked_o <= (state_reg == DS_RUN) && on_sync_reg && !req_evt;
         running_o <= (state_reg != DS_OFF) && on_sync_reg;
      end
   end

   if (LOCK_CYCLES < 1 || LOCK_CYCLES > 8191) begin : g_bad_lock
      $error("lock count out of range");
   end
endmodule : dmr_dll_core
`default_nettype wire

/* File: rtl/dmr_end.sv */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: test/dmr_mode_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dmr_mode_props (
   // clocks and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_clk_i,
   // watched ports
   input wire logic [1:0] rtt_wr_i,
   input wire logic [4:0] trp_cycles_i,
   input wire logic [2:0] wr_col_o,
   input wire logic wr_beat_o,
   input wire logic wr_ref_o,
   input wire logic rd_beat_o,
   input wire logic dq_oe_n_o,
   input wire logic dqs_oe_n_o,
   input wire logic term_wr_o,
   input wire logic [2:0] term_code_o,
   input wire logic [4:0] cas_lat_o,
   input wire logic [4:0] add_lat_o,
   input wire logic [4:0] wr_rec_o,
   input wire logic [5:0] dal_o
);
   property p_oe_beat;
      @(posedge link_clk_i) disable iff (rst_i) !dq_oe_n_o |-> rd_beat_o;
   endproperty
   a_oe_beat: assert property (p_oe_beat) else $error("data driven off a beat");
   property p_dqs_oe;
      @(posedge link_clk_i) disable iff (rst_i) dqs_oe_n_o == dq_oe_n_o;
   endproperty
   a_dqs_oe: assert property (p_dqs_oe) else $error("strobe and data enables differ");
   property p_ref_pulse;
      @(posedge link_clk_i) disable iff (rst_i) wr_ref_o |=> !wr_ref_o;
   endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("write reference too long");
   property p_wr_step;
      @(posedge link_clk_i) disable iff (rst_i)
         wr_beat_o && $past(wr_beat_o) |-> wr_col_o[1:0] == $past(wr_col_o[1:0]) + 2'h1;
   endproperty
   a_wr_step: assert property (p_wr_step) else $error("write columns not ascending");
   property p_wr_first;
      @(posedge link_clk_i) disable iff (rst_i) $rose(wr_beat_o) |-> wr_col_o[1:0] == 2'h0;
   endproperty
   a_wr_first: assert property (p_wr_first) else $error("write start column used");
   property p_dal;
      @(posedge clk_i) disable iff (rst_i) !$past(rst_i) && $stable(wr_rec_o)
         |-> dal_o == {1'b0, wr_rec_o} + {1'b0, trp_cycles_i};
   endproperty
   a_dal: assert property (p_dal) else $error("auto precharge delay wrong");
   property p_al;
      @(posedge clk_i) disable iff (rst_i)
         add_lat_o == 5'h00 || add_lat_o == cas_lat_o - 5'h01 || add_lat_o == cas_lat_o - 5'h02;
   endproperty
   a_al: assert property (p_al) else $error("additive latency off the cas scale");
   property p_term_wr;
      @(posedge link_clk_i) disable iff (rst_i) term_wr_o |-> term_code_o == {1'b0, rtt_wr_i};
   endproperty
   a_term_wr: assert property (p_term_wr) else $error("write termination code wrong");
endmodule : dmr_mode_props
bind dmr_mode_ctrl dmr_mode_props u_props (.*);
`default_nettype wire

/* File: test/dmr_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dmr_ctl_model (
   // link clock
   input wire logic link_clk_i,
   // command and address pins
   output logic cke_o,
   output logic [3:0] cmd_n_o,
   output logic [2:0] ba_o,
   output logic [12:0] addr_o,
   output logic odt_o
);
   // clock enable high from the start, so no lock wait is ever broken
   initial begin
      cke_o = 1'b1;
      cmd_n_o = 4'hf;
      ba_o = 3'h7;
      addr_o = 13'h0;
      odt_o = 1'b1;
   end
   // one command for one clock; released lines flip so stale values never match
   task automatic issue(input logic [3:0] cmd, input logic [2:0] ba, input logic [12:0] addr);
      @(posedge link_clk_i);
      cmd_n_o <= cmd;
      ba_o <= ba;
      addr_o <= addr;
      @(posedge link_clk_i);
      cmd_n_o <= 4'hf;
      ba_o <= ~ba;
      addr_o <= ~addr;
   endtask : issue
   // clock enable low for n clocks after cmd; only used while the dll is locked
   task automatic nap(input logic [3:0] cmd, input int n);
      @(posedge link_clk_i);
      cke_o <= 1'b0;
      cmd_n_o <= cmd;
      @(posedge link_clk_i);
      cmd_n_o <= 4'hf;
      repeat (n) @(posedge link_clk_i);
      cke_o <= 1'b1;
      @(posedge link_clk_i);
   endtask : nap
endmodule : dmr_ctl_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   // clocks, reset, pins and settings
   logic clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i;
   logic [2:0] ba_i;
   logic [12:0] addr_i;
   logic [4:0] cwl_i = 5'h05;
   logic [1:0] rtt_wr_i = 2'h1;
   logic [4:0] trp_cycles_i = 5'h06;
   logic rd_beat_o, dq_oe_n_o, dqs_oe_n_o, wr_beat_o, wr_ref_o, cmd_ready_o, term_wr_o;
   logic burst_ileave_o, ppd_fast_o, out_off_o, wlvl_o, dll_locked_o, dll_running_o;
   logic [2:0] rd_col_o, wr_col_o, term_code_o, rtt_nom_o;
   logic [1:0] bl_mode_o, drv_imp_o;
   logic [4:0] cas_lat_o, add_lat_o, wr_rec_o;
   logic [5:0] dal_o;
   logic [12:0] modes [4] = '{13'h1411, 13'h0419, 13'h1412, 13'h1410};
   int err_total = 0;
   int checked = 0;
   // clocks of unrelated phase
   always #25 clk_i = ~clk_i;
   always #32 link_clk_i = ~link_clk_i;
   dmr_ctl_model ctl (.link_clk_i(link_clk_i), .cke_o(cke_i),
      .cmd_n_o({cs_n_i, ras_n_i, cas_n_i, we_n_i}), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i));
   // short lock count keeps the run brief
   dmr_mode_ctrl #(.DLLK_CYCLES(8)) dut (.*);
   task automatic report_and_stop();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [5:0] seen, input logic [5:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : chk
   // settle time covers the crossing into the core domain
   task automatic mrs(input logic [2:0] ba, input logic [12:0] a);
      ctl.issue(4'h0, ba, a);
      repeat (4) @(posedge link_clk_i);
      repeat (10) @(posedge clk_i);
   endtask : mrs
   // one burst: find the first beat, then check all eight slots
   task automatic burst(input logic wr, input logic [2:0] s, input logic bc, input logic il,
      input logic fix);
      logic [2:0] e;
      logic t;
      int at;
      at = 0;
      ctl.issue({3'h2, ~wr}, 3'h0, {~bc, 9'h0, s});
      for (int n = 0; n < 40 && (wr ? wr_beat_o : rd_beat_o) !== 1'b1; n++) begin
         @(posedge link_clk_i);
         #1;
      end
      for (int i = 0; i < 8; i++) begin
         e = i[2:0];
         t = bc && i > 3;
         if (wr_ref_o === 1'b1) at = i;
         e = wr ? (bc ? {s[2], e[1:0]} : e) : (il ? s ^ e : {s[2] ^ e[2], s[1:0] + e[1:0]});
         chk(wr ? wr_beat_o : !dq_oe_n_o, !t, "beat");
         if (!wr) chk(rd_beat_o, !t, "rdb");
         chk(term_wr_o, wr, "twr");
         if (!t) chk(wr ? wr_col_o : rd_col_o, e, "col");
         @(posedge link_clk_i);
         #1;
      end
      if (wr) chk(at, fix ? 5 : 7, "ref");
   endtask : burst
   // main sequence: register one, then every burst mode with all start columns
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 99 && cmd_ready_o !== 1'b1; i++) @(posedge link_clk_i);
      chk(cmd_ready_o, 1'b1, "rdy");
      mrs(3'h1, 13'h000e);
      chk(drv_imp_o, 2'h1, "drv");
      chk(wlvl_o, 1'b0, "wl");
      chk(rtt_nom_o, 3'h1, "rtt");
      for (int m = 0; m < 4; m++) begin
         mrs(3'h0, modes[m] | 13'h0100);
         for (int i = 0; i < 99 && dll_locked_o !== 1'b1; i++) @(posedge clk_i);
         chk(dll_locked_o, 1'b1, "lock");
         chk(cas_lat_o, 5'h05, "cl");
         chk(bl_mode_o, modes[m][1:0], "bl");
         chk(burst_ileave_o, m == 1, "bt");
         chk(ppd_fast_o, m != 1, "ppd");
         chk(add_lat_o, 5'h04, "al");
         chk(wr_rec_o, 5'h06, "wr");
         chk(dal_o, 6'h0c, "dal");
         for (int s = 0; s < 8; s++) begin
            for (int b = 0; b < 4; b++) begin
               burst(b[1], s[2:0], m == 2 || (m < 2 && b[0]), m == 1, m == 2);
            end
         end
      end
      // fast-exit power-down keeps the dll; self refresh stops it and waits longer
      ctl.nap(4'hf, 8);
      chk(dll_running_o, 1'b1, "pd");
      repeat (2) @(posedge link_clk_i);
      #1 chk(cmd_ready_o, 1'b0, "xp");
      @(posedge link_clk_i);
      #1 chk(cmd_ready_o, 1'b1, "xp");
      ctl.nap(4'h1, 8);
      chk(dll_running_o, 1'b0, "sr");
      repeat (9) @(posedge link_clk_i);
      #1 chk(cmd_ready_o, 1'b0, "xs");
      @(posedge link_clk_i);
      #1 chk(cmd_ready_o, 1'b1, "xs");
      chk(dll_running_o, 1'b1, "sr");
      mrs(3'h1, 13'h100e);
      chk(out_off_o, 1'b1, "qoff");
      chk(dll_locked_o, 1'b1, "lock");
      ctl.issue(4'h5, 3'h0, 13'h1000);
      repeat (14) begin
         @(posedge link_clk_i);
         #1 chk(dq_oe_n_o, 1'b1, "float");
      end
      // dll off: write termination switched off first, nominal termination in the same set command
      @(posedge link_clk_i) rtt_wr_i <= 2'h0;
      mrs(3'h1, 13'h0001);
      chk(term_code_o, 3'h0, "toff");
      report_and_stop();
   end
   // watchdog well beyond the expected run length
   initial begin
      #2000000;
      err_total++;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
